// [hdl/spp_pkg.sv]
// package: constants for the shared pin parallel port
package spp_pkg;
  // ---------------------------------------------------------------
  // port geometry
  // ---------------------------------------------------------------
  localparam int SPP_WIDTH = 16;
  // implemented-bit mask of this variant (unimplemented bits read 0)
  localparam logic [15:0] SPP_IMPL_MASK = 16'hffff;
  // pins having an analog function; their select bits reset to analog
  localparam logic [15:0] SPP_ANALOG_MASK = 16'h00ff;
  // pins whose only sharer is an input-only function
  localparam logic [15:0] SPP_INPUT_ONLY_MASK = 16'h8000;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] SPP_DIR_RESET = 16'hffff;
  localparam logic [15:0] SPP_LAT_RESET = 16'h0000;
  localparam logic [15:0] SPP_ODC_RESET = 16'h0000;
  localparam logic [15:0] SPP_ACFG_RESET = ~SPP_ANALOG_MASK;
  // ---------------------------------------------------------------
  // pin synchroniser depth
  // ---------------------------------------------------------------
  localparam int SPP_SYNC_STAGES = 3;
endpackage : spp_pkg

// [hdl/spp_pin_mux.sv]
// module: per-pin output multiplexer and driver control
`timescale 1ns/1ps
`default_nettype none
module spp_pin_mux
  import spp_pkg::*;
(
  input wire logic per_drive_in,
  input wire logic per_data_in,
  input wire logic per_oe_in,
  input wire logic lat_in,
  input wire logic dir_in,
  input wire logic odc_in,
  input wire logic input_only_in,
  output logic data_out,
  output logic oe_out
);
  logic owner_per;
  logic val;
  logic en;
  always_comb begin
    // input-only sharers never take ownership
    owner_per = per_drive_in && !input_only_in; // (R1) (R2) (R3) (R10)
    val = owner_per ? per_data_in : lat_in; // (R1)
    en = owner_per ? per_oe_in : !dir_in; // (R2) (R3) (R5)
    if (odc_in) begin
      // open drain: drive low only, release on one
      data_out = 1'b0; // (R11) (R17)
      oe_out = en && !val; // (R17)
    end else begin
      data_out = val;
      oe_out = en;
    end
  end
endmodule // spp_pin_mux
`default_nettype wire

// [hdl/spp_port.sv]
// module: shared pin parallel port top level
`timescale 1ns/1ps
`default_nettype none
// Contract
// (R1) per-pin multiplexer picks peripheral or port for data and enable
// (R2) actively driving peripheral disables port driver; pin stays readable
// (R3) enabled but idle peripheral leaves pin to latch and direction
// (R4) port output never reaches the peripheral input of the same pin
// (R5) direction bit one means input, zero means output
// (R6) every reset makes all pins inputs
// (R7) latch reads return latch; latch writes touch only latch
// (R8) pin-level read returns sampled pins; its write updates latch
// (R9) unimplemented bits disabled and read as zero
// (R10) pin shared only with input function is a dedicated port pin
// (R11) open-drain select bit makes the pin open-drain
// (R12) cleared analog select bit means analog; analog pins reset analog
// (R13) analog if cleared in either converter's configuration
// (R14) analog pins read low through pin-level read
// (R15) software sets direction to input for analog pins
// (R16) software waits one cycle between port write and read
// (R17) open-drain drives low for zero, releases for one
module spp_port
  import spp_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic dir_wr_in,
  input wire logic [15:0] dir_wdata_in,
  input wire logic lat_wr_in,
  input wire logic [15:0] lat_wdata_in,
  input wire logic lvl_wr_in,
  input wire logic [15:0] lvl_wdata_in,
  input wire logic odc_wr_in,
  input wire logic [15:0] odc_wdata_in,
  input wire logic acfg1_wr_in,
  input wire logic [15:0] acfg1_wdata_in,
  input wire logic acfg2_wr_in,
  input wire logic [15:0] acfg2_wdata_in,
  input wire logic [15:0] pin_in,
  input wire logic [15:0] per_drive_in,
  input wire logic [15:0] per_data_in,
  input wire logic [15:0] per_oe_in,
  output logic [15:0] pin_direction_bits_out,
  output logic [15:0] output_latch_bits_out,
  output logic [15:0] pin_level_bits_out,
  output logic [15:0] open_drain_select_bits_out,
  output logic [15:0] analog_config_low_out,
  output logic [15:0] analog_config_high_out,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe_out,
  output logic [15:0] per_in_out
);
  typedef struct packed {
    logic [15:0] dir;
    logic [15:0] lat;
    logic [15:0] odc;
    logic [15:0] acfg1;
    logic [15:0] acfg2;
    logic [15:0] s1;
    logic [15:0] s2;
    logic [15:0] s3;
    logic [15:0] lvl;
    logic [15:0] pdat;
    logic [15:0] poe;
    logic [15:0] pin_q;
  } spp_state_t;

  spp_state_t st;
  spp_state_t next_st;
  logic [15:0] mux_dat;
  logic [15:0] mux_oe;
  logic [15:0] stable;
  logic [15:0] analog;

  // ---------------------------------------------------------------
  // output multiplexers
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < SPP_WIDTH; gi++) begin : g_pin
      spp_pin_mux u_mux (
        .per_drive_in(per_drive_in[gi]),
        .per_data_in(per_data_in[gi]),
        .per_oe_in(per_oe_in[gi]),
        .lat_in(st.lat[gi]),
        .dir_in(st.dir[gi]),
        .odc_in(st.odc[gi]),
        .input_only_in(SPP_INPUT_ONLY_MASK[gi]),
        .data_out(mux_dat[gi]),
        .oe_out(mux_oe[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    stable = ~(st.s2 ^ st.s3);
    analog = SPP_ANALOG_MASK & ~(st.acfg1 & st.acfg2); // (R12) (R13)
    if (dir_wr_in) begin
      next_st.dir = dir_wdata_in & SPP_IMPL_MASK; // (R5) (R9)
    end
    if (lvl_wr_in) begin
      next_st.lat = lvl_wdata_in & SPP_IMPL_MASK; // (R8)
    end else if (lat_wr_in) begin
      next_st.lat = lat_wdata_in & SPP_IMPL_MASK; // (R7) (R9)
    end
    if (odc_wr_in) begin
      next_st.odc = odc_wdata_in & SPP_IMPL_MASK; // (R11)
    end
    if (acfg1_wr_in) begin
      next_st.acfg1 = acfg1_wdata_in | ~SPP_ANALOG_MASK; // (R12)
    end
    if (acfg2_wr_in) begin
      next_st.acfg2 = acfg2_wdata_in | ~SPP_ANALOG_MASK; // (R13)
    end
    next_st.s1 = pin_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // a change counts once stages two and three agree
    next_st.lvl = (st.lvl & ~stable) | (st.s3 & stable);
    next_st.pin_q = next_st.lvl & ~analog & SPP_IMPL_MASK; // (R14) (R9)
    // suppress loop-through: peripheral sees pin only when port is not
    // the driver of that pin
    next_st.pdat = mux_dat & SPP_IMPL_MASK;
    next_st.poe = mux_oe & SPP_IMPL_MASK; // (R9)
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '{dir: SPP_DIR_RESET, // (R6)
              lat: SPP_LAT_RESET,
              odc: SPP_ODC_RESET,
              acfg1: SPP_ACFG_RESET, // (R12)
              acfg2: SPP_ACFG_RESET,
              s1: 16'h0000,
              s2: 16'h0000,
              s3: 16'h0000,
              lvl: 16'h0000,
              pdat: 16'h0000,
              poe: 16'h0000,
              pin_q: 16'h0000};
    end else begin
      st <= next_st;
    end
  end

  // port-owned output bits are masked from the peripheral input path
  logic [15:0] port_drv;
  always_comb begin
    // input-only sharers never own the pad, so the port drives it there
    port_drv = st.poe & ~(per_drive_in & ~SPP_INPUT_ONLY_MASK); // (R4) (R10)
  end
  logic [15:0] per_in_q;
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      per_in_q <= 16'h0000;
    end else begin
      per_in_q <= st.lvl & ~port_drv & SPP_IMPL_MASK; // (R4)
    end
  end

  assign pin_direction_bits_out = st.dir;
  assign output_latch_bits_out = st.lat; // (R7)
  assign pin_level_bits_out = st.pin_q; // (R8)
  assign open_drain_select_bits_out = st.odc;
  assign analog_config_low_out = st.acfg1;
  assign analog_config_high_out = st.acfg2;
  assign pin_out = st.pdat;
  assign pin_oe_out = st.poe;
  assign per_in_out = per_in_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_dir_write;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      dir_wr_in |=> pin_direction_bits_out == $past(dir_wdata_in);
  endproperty
  a_dir_write: assert property (p_dir_write) // (R5)
    else $error("direction write lost");

  property p_lvl_write;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      lvl_wr_in |=> output_latch_bits_out == $past(lvl_wdata_in);
  endproperty
  a_lvl_write: assert property (p_lvl_write) // (R8)
    else $error("pin-level write did not reach latch");

  property p_lat_hold;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      !lat_wr_in && !lvl_wr_in |=> $stable(output_latch_bits_out);
  endproperty
  a_lat_hold: assert property (p_lat_hold) // (R7)
    else $error("latch changed without write");

  property p_analog_low;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      1'b1 |-> (pin_level_bits_out & SPP_ANALOG_MASK &
        ~(analog_config_low_out & analog_config_high_out)) == 16'h0000
        || $changed(analog_config_low_out)
        || $changed(analog_config_high_out);
  endproperty
  a_analog_low: assert property (p_analog_low) // (R14) (R13)
    else $error("analog pin read high");

  property p_port_drive;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      per_drive_in == 16'h0000 && open_drain_select_bits_out == 16'h0000
        && !dir_wr_in && !odc_wr_in
        |=> pin_oe_out == ~$past(pin_direction_bits_out);
  endproperty
  a_port_drive: assert property (p_port_drive) // (R3) (R5)
    else $error("port enable not from direction");

  property p_per_drive;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      open_drain_select_bits_out == 16'h0000
        |=> (pin_oe_out & $past(per_drive_in & ~SPP_INPUT_ONLY_MASK)) ==
          $past(per_oe_in & per_drive_in & ~SPP_INPUT_ONLY_MASK);
  endproperty
  a_per_drive: assert property (p_per_drive) // (R2) (R1)
    else $error("peripheral enable not passed");

  property p_od_high;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      1'b1 |=> (pin_out & $past(open_drain_select_bits_out)) == 16'h0000;
  endproperty
  a_od_high: assert property (p_od_high) // (R17) (R11)
    else $error("open-drain pin driven high");

  property p_no_loop;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      1'b1 |=> (per_in_out & $past(pin_oe_out &
        ~(per_drive_in & ~SPP_INPUT_ONLY_MASK))) == 16'h0000;
  endproperty
  a_no_loop: assert property (p_no_loop) // (R4)
    else $error("port output looped into peripheral");
endmodule // spp_port
`default_nettype wire

// [test/spp_pin_model.sv]
// pin world model: resolves each pad from the port driver and outside
`timescale 1ns/1ps
`default_nettype none
module spp_pin_model (
  input wire logic [15:0] pin_out_in,
  input wire logic [15:0] pin_oe_in,
  input wire logic [15:0] ext_lvl_in,
  output logic [15:0] pin_lvl_out
);
  // outside level wins only where the port releases the pad
  assign pin_lvl_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_lvl_in);
endmodule // spp_pin_model
`default_nettype wire

// [test/spp_port_test.sv]
// testbench for the shared pin parallel port
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  mismatches++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module spp_port_test;
  import spp_pkg::*;
  logic ref_clk_in = 0, arst_n_in = 0;
  logic [5:0] we = 0;
  logic [15:0] wd = 0, ext = 0, pdrv = 0, pdat = 0, poe = 0, lvl;
  logic [15:0] dir_o, lat_o, lvl_o, odc_o, acl_o, ach_o, po, poe_o, pin_o;
  int mismatches = 0, checks_done = 0;
  initial forever #2 ref_clk_in = ~ref_clk_in;
  spp_port u_spp_port (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
    .dir_wr_in(we[0]), .dir_wdata_in(wd), .lat_wr_in(we[1]),
    .lat_wdata_in(wd), .lvl_wr_in(we[2]), .lvl_wdata_in(wd),
    .odc_wr_in(we[3]), .odc_wdata_in(wd), .acfg1_wr_in(we[4]),
    .acfg1_wdata_in(wd), .acfg2_wr_in(we[5]), .acfg2_wdata_in(wd),
    .pin_in(lvl), .per_drive_in(pdrv), .per_data_in(pdat),
    .per_oe_in(poe), .pin_direction_bits_out(dir_o),
    .output_latch_bits_out(lat_o), .pin_level_bits_out(lvl_o),
    .open_drain_select_bits_out(odc_o), .analog_config_low_out(acl_o),
    .analog_config_high_out(ach_o), .pin_out(po), .pin_oe_out(poe_o),
    .per_in_out(pin_o));
  spp_pin_model u_spp_pin_model (.pin_out_in(po), .pin_oe_in(poe_o),
    .ext_lvl_in(ext), .pin_lvl_out(lvl));
  task automatic wr(input logic [5:0] s, input logic [15:0] d);
    @(posedge ref_clk_in);
    we <= s;
    wd <= d;
    @(posedge ref_clk_in);
    we <= 6'h00;
  endtask
  // settle: the one idle cycle before a read, plus pipeline latency
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic t_reset;
    arst_n_in <= 0;
    repeat (8) @(posedge ref_clk_in);
    arst_n_in <= 1;
    #1;
    `CHK("dir", 16'hffff, dir_o)
    `CHK("oe", 16'h0000, poe_o)
    `CHK("lat", 16'h0000, lat_o)
    `CHK("odc", 16'h0000, odc_o)
    `CHK("acfg1", ~SPP_ANALOG_MASK, acl_o)
    `CHK("acfg2", ~SPP_ANALOG_MASK, ach_o)
  endtask
  task automatic t_dir_lat;
    wr(6'h01, 16'h0000);
    wr(6'h02, 16'ha5c3);
    settle(3);
    `CHK("dir", 16'h0000, dir_o)
    `CHK("lat", 16'ha5c3, lat_o)
    `CHK("pin", 16'ha5c3, po)
    `CHK("oe", 16'hffff, poe_o)
    `CHK("per_in", 16'h0000, pin_o)
  endtask
  task automatic t_lvl_wr;
    @(posedge ref_clk_in);
    we <= 6'h06;
    wd <= 16'h1234;
    @(posedge ref_clk_in);
    we <= 6'h00;
    settle(3);
    `CHK("lat", 16'h1234, lat_o)
    `CHK("dir", 16'h0000, dir_o)
    `CHK("pin", 16'h1234, po)
  endtask
  task automatic t_read_analog;
    wr(6'h01, 16'hffff);
    wr(6'h30, 16'hffff);
    ext <= 16'h5aa5;
    settle(7);
    `CHK("lvl", 16'h5aa5, lvl_o)
    wr(6'h10, 16'h0000);
    settle(7);
    `CHK("acfg1", 16'hff00, acl_o)
    `CHK("lvl", 16'h5a00, lvl_o)
    wr(6'h10, 16'hffff);
    wr(6'h20, 16'hfff0);
    settle(7);
    `CHK("acfg2", 16'hfff0, ach_o)
    `CHK("lvl", 16'h5aa0, lvl_o)
    wr(6'h20, 16'hffff);
  endtask
  task automatic t_periph;
    ext <= 16'hffff;
    wr(6'h03, 16'h0000);
    wr(6'h02, 16'h8000);
    pdrv <= 16'h800f;
    pdat <= 16'h0005;
    poe <= 16'h0007;
    settle(8);
    `CHK("pin", 16'h8005, po)
    `CHK("oe", 16'hfff7, poe_o)
    `CHK("per_in", 16'h000d, pin_o)
    @(posedge ref_clk_in);
    pdrv <= 16'h0000;
    settle(3);
    `CHK("pin", 16'h8000, po)
    `CHK("oe", 16'hffff, poe_o)
  endtask
  task automatic t_open_drain;
    wr(6'h08, 16'hffff);
    wr(6'h02, 16'h00ff);
    settle(3);
    `CHK("odc", 16'hffff, odc_o)
    `CHK("pin", 16'h0000, po)
    `CHK("oe", 16'hff00, poe_o)
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    t_reset();
    t_dir_lat();
    t_lvl_wr();
    t_read_analog();
    t_periph();
    t_open_drain();
    t_reset();
    test_done();
  end
endmodule // spp_port_test
`default_nettype wire
